// >>> inc/regulator_control_pkg.sv
package regulator_control_pkg;

    // ------------------------------------------------------------
    // register indexes (printed offsets are not word multiples)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_BUCK2_LEVEL   = 8'h30;
    localparam logic [7:0] IDX_BUCK2_SPARE   = 8'h31;
    localparam logic [7:0] IDX_BUCK2_CONTROL = 8'h32;
    localparam logic [7:0] IDX_BUCK3_LEVEL   = 8'h40;
    localparam logic [7:0] IDX_BUCK3_SPARE   = 8'h41;
    localparam logic [7:0] IDX_BUCK3_CONTROL = 8'h42;
    localparam logic [7:0] IDX_LIN4_LEVEL    = 8'h50;
    localparam logic [7:0] IDX_LIN4_CONTROL  = 8'h51;
    localparam logic [7:0] IDX_IRQ_STATUS    = 8'h70;
    localparam logic [7:0] IDX_IRQ_MASK      = 8'h71;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int LEVEL_W    = 6;
    localparam int DELAY_W    = 3;
    localparam int BIT_ON     = 7;
    localparam int BIT_SEL6   = 6;
    localparam int BIT_SEL5   = 5;
    localparam int DELAY_LO   = 2;
    localparam int DELAY_HI   = 4;
    localparam int BIT_FMASK  = 1;
    localparam int BIT_PGOOD  = 0;
    localparam int NUM_REG    = 3;
    localparam int IRQ_W      = 6;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_LEVEL   = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [IRQ_W-1:0] RST_IRQ = 6'h00;

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // byte address of a register index
    function automatic logic [9:0] byte_addr(input logic [7:0] idx);
        return {idx, 2'h0};
    endfunction

endpackage

// >>> src/event_sticky.sv
`timescale 1ns/10ps
// sticky event flags, write-one-to-clear, set wins over clear
module event_sticky #(
    parameter int W = 6
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clear_i,
    output logic      [W-1:0] flags_q
);
    if (W < 1) begin : g_bad_w
        $error("event_sticky: W must be positive");
    end

    // set applied after clear so an event in the clearing cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~clear_i) | set_i;
        end
    end

    a_set_wins_clear : assert property (@(posedge aclk) disable iff (!aresetn)
        (set_i != '0) |=> ((flags_q & $past(set_i)) == $past(set_i)))
        else $error("event flag lost while being cleared");
endmodule // event_sticky

// >>> src/regulator_control_regs.sv
`timescale 1ns/10ps
// What this block does
// - six-bit level code; top two bits read zero
// - control bit 7 turns regulator on
// - second converter bit 6 selects opposite phase
// - converter bit 5 forces fixed-frequency switching
// - converter bits 4:2 hold turn-on delay
// - bit 1 allows regulator fault interrupts
// - bit 0 reads power-good, writes ignored
// - third converter bit 6 zero follows push key
// - linear bit 6 bleeds output while off
// - linear bit 5 selects low quiescent mode
// - linear bits 4:2 hold turn-on delay
module regulator_control_regs
    import regulator_control_pkg::*;
(
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // axi4-lite slave
    input  wire logic [11:0]               s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [11:0]               s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // analog side: index 0 buck2, 1 buck3, 2 linear4
    input  wire logic [NUM_REG-1:0]        power_good,
    input  wire logic [NUM_REG-1:0]        fault,
    input  wire logic                      push_key_input,
    output logic [regulator_control_pkg::LEVEL_W-1:0] buck2_output_level_code,
    output logic [regulator_control_pkg::LEVEL_W-1:0] buck3_output_level_code,
    output logic [regulator_control_pkg::LEVEL_W-1:0] linear4_output_level_code,
    output logic [NUM_REG-1:0]             reg_enable,
    output logic                           buck2_phase_opposite,
    output logic [1:0]                     buck_fixed_freq,
    output logic [regulator_control_pkg::DELAY_W-1:0] buck2_delay_code,
    output logic [regulator_control_pkg::DELAY_W-1:0] buck3_delay_code,
    output logic [regulator_control_pkg::DELAY_W-1:0] linear4_delay_code,
    output logic                           output_bleed_enable,
    output logic                           quiescent_saver,
    output logic                           irq
);
    import regulator_control_pkg::*;

    // the readback and status layouts are built for exactly three regulators
    if (NUM_REG != 3 || IRQ_W != 2 * NUM_REG) begin : g_bad_layout
        $error("regulator_control_regs: layout needs three regulators");
    end

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [LEVEL_W-1:0] level_q [NUM_REG];
    logic [7:1]         ctrl_q  [NUM_REG];
    logic [IRQ_W-1:0]   irq_mask_q;
    logic [IRQ_W-1:0]   irq_flags;
    logic [IRQ_W-1:0]   irq_clear;
    logic [IRQ_W-1:0]   irq_set;
    logic [NUM_REG-1:0] fault_rise;
    logic [NUM_REG-1:0] pgood_fall;
    logic [NUM_REG-1:0] fault_allowed;

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    logic        aw_held_q;
    logic        w_held_q;
    logic [9:0]  waddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        do_write;
    logic        wr_hit;

    // address and data may arrive in either order; both are latched
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            waddr_q       <= '0;
            wdata_q       <= '0;
            wstrb_q       <= '0;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid && !do_write;
            s_axi_wready  <= !w_held_q && !s_axi_wready && !s_axi_bvalid && !do_write;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                waddr_q   <= s_axi_awaddr[9:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
            end
        end
    end

    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

    // decode a byte address into a hit flag
    function automatic logic addr_known(input logic [9:0] a);
        return a == byte_addr(IDX_BUCK2_LEVEL) || a == byte_addr(IDX_BUCK2_SPARE)
            || a == byte_addr(IDX_BUCK2_CONTROL) || a == byte_addr(IDX_BUCK3_LEVEL)
            || a == byte_addr(IDX_BUCK3_SPARE) || a == byte_addr(IDX_BUCK3_CONTROL)
            || a == byte_addr(IDX_LIN4_LEVEL) || a == byte_addr(IDX_LIN4_CONTROL)
            || a == byte_addr(IDX_IRQ_STATUS) || a == byte_addr(IDX_IRQ_MASK);
    endfunction

    assign wr_hit = addr_known(waddr_q);

    // readies stay low while a response waits, so a second write cannot overtake it
    // write response one cycle after both halves are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register updates (only byte lane 0 carries data)
    // ------------------------------------------------------------
    logic lane0_wr;
    assign lane0_wr = do_write && wstrb_q[0];

    // level codes; bits 7:6 are not stored so they read zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_REG; i++) level_q[i] <= RST_LEVEL[LEVEL_W-1:0];
        end else if (lane0_wr) begin
            if (waddr_q == byte_addr(IDX_BUCK2_LEVEL)) level_q[0] <= wdata_q[LEVEL_W-1:0];
            if (waddr_q == byte_addr(IDX_BUCK3_LEVEL)) level_q[1] <= wdata_q[LEVEL_W-1:0];
            if (waddr_q == byte_addr(IDX_LIN4_LEVEL))  level_q[2] <= wdata_q[LEVEL_W-1:0];
        end
    end

    // control bits 7:1; bit 0 has no storage so writes to it vanish
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_REG; i++) ctrl_q[i] <= RST_CONTROL[7:1];
        end else if (lane0_wr) begin
            if (waddr_q == byte_addr(IDX_BUCK2_CONTROL)) ctrl_q[0] <= wdata_q[7:1];
            if (waddr_q == byte_addr(IDX_BUCK3_CONTROL)) ctrl_q[1] <= wdata_q[7:1];
            if (waddr_q == byte_addr(IDX_LIN4_CONTROL))  ctrl_q[2] <= wdata_q[7:1];
        end
    end

    // interrupt mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_q <= RST_IRQ;
        end else if (lane0_wr && waddr_q == byte_addr(IDX_IRQ_MASK)) begin
            irq_mask_q <= wdata_q[IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------
    rise_detect #(.W(NUM_REG)) u_fault_edge (
        .aclk    (aclk),
        .aresetn (aresetn),
        .level_i (fault),
        .rise_o  (fault_rise)
    );

    rise_detect #(.W(NUM_REG)) u_pgood_edge (
        .aclk    (aclk),
        .aresetn (aresetn),
        .level_i (~power_good),
        .rise_o  (pgood_fall)
    );

    // a fault counts only while that regulator's allow bit is 1
    always_comb begin
        for (int i = 0; i < NUM_REG; i++) fault_allowed[i] = fault_rise[i] & ctrl_q[i][BIT_FMASK];
    end

    assign irq_set   = {pgood_fall, fault_allowed};
    assign irq_clear = (lane0_wr && waddr_q == byte_addr(IDX_IRQ_STATUS)) ? wdata_q[IRQ_W-1:0] : '0;

    event_sticky #(.W(IRQ_W)) u_status (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set_i   (irq_set),
        .clear_i (irq_clear),
        .flags_q (irq_flags)
    );

    // registered so the pin comes straight from a flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_flags & irq_mask_q);
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    function automatic logic [7:0] read_mux(input logic [9:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == byte_addr(IDX_BUCK2_LEVEL))   v = {2'h0, level_q[0]};
        if (a == byte_addr(IDX_BUCK3_LEVEL))   v = {2'h0, level_q[1]};
        if (a == byte_addr(IDX_LIN4_LEVEL))    v = {2'h0, level_q[2]};
        if (a == byte_addr(IDX_BUCK2_CONTROL)) v = {ctrl_q[0], power_good[0]};
        if (a == byte_addr(IDX_BUCK3_CONTROL)) v = {ctrl_q[1], power_good[1]};
        if (a == byte_addr(IDX_LIN4_CONTROL))  v = {ctrl_q[2], power_good[2]};
        if (a == byte_addr(IDX_IRQ_STATUS))    v = {2'h0, irq_flags};
        if (a == byte_addr(IDX_IRQ_MASK))      v = {2'h0, irq_mask_q};
        return v;
    endfunction

    // only byte lane 0 has storage behind it; upper lanes always read zero
    // address taken one cycle, data returned the next
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, read_mux(s_axi_araddr[9:0])};
                s_axi_rresp  <= addr_known(s_axi_araddr[9:0]) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // regulator controls, registered
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buck2_output_level_code   <= '0;
            buck3_output_level_code   <= '0;
            linear4_output_level_code <= '0;
            reg_enable                <= '0;
            buck2_phase_opposite      <= 1'b0;
            buck_fixed_freq           <= '0;
            buck2_delay_code          <= '0;
            buck3_delay_code          <= '0;
            linear4_delay_code        <= '0;
            output_bleed_enable       <= 1'b0;
            quiescent_saver           <= 1'b0;
        end else begin
            buck2_output_level_code   <= level_q[0];
            buck3_output_level_code   <= level_q[1];
            linear4_output_level_code <= level_q[2];
            reg_enable[0] <= ctrl_q[0][BIT_ON];
            // push-key follow: with bit 6 low, an asserted key also enables
            reg_enable[1] <= ctrl_q[1][BIT_ON] | (!ctrl_q[1][BIT_SEL6] & push_key_input);
            reg_enable[2] <= ctrl_q[2][BIT_ON];
            buck2_phase_opposite <= ctrl_q[0][BIT_SEL6];
            buck_fixed_freq      <= {ctrl_q[1][BIT_SEL5], ctrl_q[0][BIT_SEL5]};
            buck2_delay_code     <= ctrl_q[0][DELAY_HI:DELAY_LO];
            buck3_delay_code     <= ctrl_q[1][DELAY_HI:DELAY_LO];
            linear4_delay_code   <= ctrl_q[2][DELAY_HI:DELAY_LO];
            // bleed only while the regulator is shut down
            output_bleed_enable  <= ctrl_q[2][BIT_SEL6] & !ctrl_q[2][BIT_ON];
            quiescent_saver      <= ctrl_q[2][BIT_SEL5];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_enable_follows : assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> reg_enable[0] == $past(ctrl_q[0][BIT_ON]))
        else $error("buck2 enable does not follow control bit");
    a_phase_follows : assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> buck2_phase_opposite == $past(ctrl_q[0][BIT_SEL6]))
        else $error("phase select wrong");
    a_level_top_zero : assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr[9:0] == byte_addr(IDX_BUCK2_LEVEL))
        |=> s_axi_rdata[7:6] == 2'h0 && s_axi_rdata[5:0] == $past(level_q[0]))
        else $error("level read wrong");
    a_pgood_read : assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr[9:0] == byte_addr(IDX_BUCK3_CONTROL))
        |=> s_axi_rdata[BIT_PGOOD] == $past(power_good[1]))
        else $error("power-good read wrong");
    a_push_key_en : assert property (@(posedge aclk) disable iff (!aresetn)
        (push_key_input && !ctrl_q[1][BIT_SEL6]) |=> reg_enable[1])
        else $error("push key did not enable buck3");
    a_bleed_off : assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_q[2][BIT_ON] |=> !output_bleed_enable)
        else $error("bleed on while running");
    a_quiet_mode : assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> quiescent_saver == $past(ctrl_q[2][BIT_SEL5]))
        else $error("quiescent select wrong");
    a_delay_codes : assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> buck3_delay_code == $past(ctrl_q[1][DELAY_HI:DELAY_LO])
            && linear4_delay_code == $past(ctrl_q[2][DELAY_HI:DELAY_LO]))
        else $error("delay code wrong");
    a_fault_blocked : assert property (@(posedge aclk) disable iff (!aresetn)
        (fault_rise[0] && !ctrl_q[0][BIT_FMASK]) |-> !irq_set[0])
        else $error("blocked fault raised event");
    a_irq_raise : assert property (@(posedge aclk) disable iff (!aresetn)
        (fault_rise[2] && ctrl_q[2][BIT_FMASK] && irq_mask_q[2]) |-> ##2 irq)
        else $error("allowed fault raised no interrupt");
    a_fixed_freq : assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> buck_fixed_freq[1] == $past(ctrl_q[1][BIT_SEL5]))
        else $error("mode select wrong");
    a_bleed_on : assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl_q[2][BIT_SEL6] && !ctrl_q[2][BIT_ON]) |=> output_bleed_enable)
        else $error("no bleed in shutdown");
    a_fault_flag : assert property (@(posedge aclk) disable iff (!aresetn)
        (fault_rise[2] && ctrl_q[2][BIT_FMASK]) |=> irq_flags[2])
        else $error("allowed fault not flagged");
    a_mask_gate : assert property (@(posedge aclk) disable iff (!aresetn)
        (irq_flags & irq_mask_q) == '0 |=> !irq)
        else $error("irq with nothing unmasked");
endmodule // regulator_control_regs

// >>> src/rise_detect.sv
`timescale 1ns/10ps
// one-cycle pulse on each rising edge of a vector of levels
module rise_detect #(
    parameter int W = 3
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] level_i,
    output logic      [W-1:0] rise_o
);
    logic [W-1:0] prev_q;

    if (W < 1) begin : g_bad_w
        $error("rise_detect: W must be positive");
    end

    // remember last level; in reset it tracks the pin so release makes no false edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= level_i;
        end else begin
            prev_q <= level_i;
        end
    end

    assign rise_o = level_i & ~prev_q;
endmodule // rise_detect

// >>> testbench/regulator_control_regs_tb.sv
`timescale 1ns/10ps
module regulator_control_regs_tb;
    import regulator_control_pkg::*;

    // ------------------------------------------------------------
    // signals and bench state
    // ------------------------------------------------------------
    logic        aclk, aresetn, push_key_input, irq;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, buck_fixed_freq, rsp;
    logic [2:0]  power_good, fault, reg_enable, buck2_delay_code, buck3_delay_code, linear4_delay_code;
    logic [5:0]  buck2_output_level_code, buck3_output_level_code, linear4_output_level_code;
    logic        buck2_phase_opposite, output_bleed_enable, quiescent_saver;
    logic [7:0]  k;
    logic [7:0]  mem [256];
    logic [7:0]  wt [6] = '{IDX_BUCK2_LEVEL, IDX_BUCK2_CONTROL, IDX_BUCK3_LEVEL, IDX_BUCK3_CONTROL,
                            IDX_LIN4_LEVEL, IDX_LIN4_CONTROL};
    int          seed = 32'h688273df;
    int          miscompares = 0;
    int          checks_done = 0;

    regulator_control_regs DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_good,
        .fault, .push_key_input, .buck2_output_level_code, .buck3_output_level_code, .linear4_output_level_code,
        .reg_enable, .buck2_phase_opposite, .buck_fixed_freq, .buck2_delay_code, .buck3_delay_code,
        .linear4_delay_code, .output_bleed_enable, .quiescent_saver, .irq);

    // free-running 10 MHz clock
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks made %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            miscompares++;
        end
    endtask

    task automatic timeout(input string what);
        $display("unexpected %s: expected an answer, seen none", what);
        miscompares++;
        stop_test();
    endtask

    // ------------------------------------------------------------
    // expectations, worked out from the bench's own copy of the registers
    // ------------------------------------------------------------
    function automatic logic [31:0] exp_rd(input logic [7:0] idx);
        case (idx)
            IDX_BUCK2_LEVEL, IDX_BUCK3_LEVEL, IDX_LIN4_LEVEL, IDX_IRQ_MASK: return {26'h0, mem[idx][5:0]};
            IDX_BUCK2_CONTROL: return {24'h0, mem[idx][7:1], power_good[0]};
            IDX_BUCK3_CONTROL: return {24'h0, mem[idx][7:1], power_good[1]};
            IDX_LIN4_CONTROL:  return {24'h0, mem[idx][7:1], power_good[2]};
            default:           return 32'h0;
        endcase
    endfunction

    function automatic logic [31:0] exp_pins();
        logic [7:0] b2, b3, l4;
        b2 = mem[IDX_BUCK2_CONTROL];
        b3 = mem[IDX_BUCK3_CONTROL];
        l4 = mem[IDX_LIN4_CONTROL];
        return {15'h0, l4[7], b3[7] | (push_key_input & ~b3[6]), b2[7], b2[6], b3[5], b2[5],
                b2[4:2], b3[4:2], l4[4:2], l4[6] & ~l4[7], l4[5]};
    endfunction

    // ------------------------------------------------------------
    // axi4-lite master: values are taken at the negedge before the sampling edge, so no race
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd, output logic [1:0] resp);
        logic a, w, done;
        int n;
        done = 1'b0;
        resp = 2'h3;
        @(posedge aclk);
        s_axi_awaddr  <= {2'h0, idx, 2'h0};
        s_axi_wdata   <= wd;
        s_axi_wstrb   <= {3'($random(seed)), 1'b1};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 64 && !done; n++) begin
            @(negedge aclk);
            a = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            done = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (a) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (done) s_axi_bready <= 1'b0;
        end
        if (!done) timeout("write response");
        if (resp === RESP_OKAY) mem[idx] = wd[7:0];
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] exp_resp);
        logic a, done;
        logic [31:0] rdv;
        logic [1:0] resp;
        int n;
        done = 1'b0;
        @(posedge aclk);
        s_axi_araddr  <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 64 && !done; n++) begin
            @(negedge aclk);
            a = s_axi_arvalid && s_axi_arready;
            done = s_axi_rvalid;
            rdv = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (a) s_axi_arvalid <= 1'b0;
            if (done) s_axi_rready <= 1'b0;
        end
        if (!done) timeout("read response");
        chk($sformatf("read data at index %h", idx), exp, rdv);
        chk($sformatf("read response at index %h", idx), 32'(exp_resp), 32'(resp));
    endtask

    // control pins lag the register by one cycle, so look at them a settled half cycle later
    task automatic pchk();
        @(negedge aclk);
        chk("control pins", exp_pins(), 32'({reg_enable, buck2_phase_opposite, buck_fixed_freq, buck2_delay_code,
            buck3_delay_code, linear4_delay_code, output_bleed_enable, quiescent_saver}));
        chk("level pins", 32'({mem[IDX_BUCK2_LEVEL][5:0], mem[IDX_BUCK3_LEVEL][5:0], mem[IDX_LIN4_LEVEL][5:0]}),
            32'({buck2_output_level_code, buck3_output_level_code, linear4_output_level_code}));
        @(posedge aclk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {power_good, fault, push_key_input} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (wt[i]) rchk(wt[i], exp_rd(wt[i]), RESP_OKAY);
        pchk();
        $display("test reset values done");
        // first two passes pin the push-key corner, the rest are random
        for (int i = 0; i < 40; i++) begin
            k = (i < 2) ? IDX_BUCK3_CONTROL : wt[$unsigned($random(seed)) % 6];
            d = (i < 2) ? {25'h0, i[0], 6'h00} : $random(seed);
            push_key_input <= (i < 2) ? 1'b1 : 1'($random(seed));
            power_good <= 3'($random(seed));
            wr(k, d, rsp);
            chk("write response", 32'(RESP_OKAY), 32'(rsp));
            rchk(k, exp_rd(k), RESP_OKAY);
            pchk();
        end
        $display("test random registers done");
        wr(IDX_BUCK2_SPARE, 32'hFF, rsp);
        rchk(IDX_BUCK2_SPARE, 32'h0, RESP_OKAY);
        rchk(IDX_BUCK3_SPARE, 32'h0, RESP_OKAY);
        wr(8'h33, 32'hFF, rsp);
        chk("unmapped write response", 32'(RESP_SLVERR), 32'(rsp));
        rchk(8'h33, 32'h0, RESP_SLVERR);
        $display("test reserved places done");
        power_good <= 3'h7;
        wr(IDX_IRQ_MASK, 32'h0, rsp);
        wr(IDX_BUCK2_CONTROL, 32'h02, rsp);
        wr(IDX_BUCK3_CONTROL, 32'h00, rsp);
        wr(IDX_IRQ_STATUS, 32'h3F, rsp);
        fault <= 3'b011;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk("irq while masked", 32'h0, 32'(irq));
        rchk(IDX_IRQ_STATUS, 32'h01, RESP_OKAY);
        wr(IDX_IRQ_MASK, 32'h01, rsp);
        rchk(IDX_IRQ_MASK, 32'h01, RESP_OKAY);
        @(negedge aclk);
        chk("irq while allowed", 32'h1, 32'(irq));
        @(posedge aclk);
        fault <= 3'b000;
        wr(IDX_IRQ_STATUS, 32'h01, rsp);
        repeat (2) @(negedge aclk);
        chk("irq after clear", 32'h0, 32'(irq));
        rchk(IDX_IRQ_STATUS, 32'h0, RESP_OKAY);
        wr(IDX_LIN4_CONTROL, 32'h02, rsp);
        wr(IDX_IRQ_MASK, 32'h04, rsp);
        fault <= 3'b100;
        power_good <= 3'h5;
        repeat (4) @(posedge aclk);
        rchk(IDX_IRQ_STATUS, 32'h14, RESP_OKAY);
        @(negedge aclk);
        chk("irq from linear fault", 32'h1, 32'(irq));
        $display("test interrupt done");
        stop_test();
    end
endmodule // regulator_control_regs_tb
